// [design/card_config_register_bank.sv]
/*
 * Card configuration register bank: option, configuration-and-status and
 * pin-replacement registers in attribute memory, with soft reset, decode
 * selection, state-change pin, power-down handshake and change flags.
 * Assumes the pin strobes are synchronised to mclk; the ATA core supplies
 * the interrupt, idle and command indications on mclk.
 */
`timescale 1ns/1ps
`include "card_cfg_map.svh"

module card_config_register_bank
    import card_cfg_pkg::*;
(
    // Clock and reset
    input  wire logic      mclk,
    input  wire logic      rst,
    // Attribute memory strobes
    input  wire attr_bus_s attr_bus,
    output logic [7:0]     rdata,
    output logic           rdata_oe,
    // Core status
    input  wire logic      core_irq,
    input  wire logic      irq_disable_bit,
    input  wire logic      core_ready,
    input  wire logic      core_idle,
    input  wire logic      core_command,
    input  wire logic      power_reached,
    // Control outputs
    output card_ctl_s      card_ctl,
    output logic           status_change_out,
    output logic           ready_busy_out,
    output logic           power_down_active
);

    logic [7:0] opt_q;
    logic [7:0] opt_d;
    logic       change_signal_enable_q;
    logic       change_signal_enable_d;
    logic       byteio_q;
    logic       byteio_d;
    logic       psave_q;
    logic       psave_d;
    logic       rdychg_q;
    logic       rdychg_d;
    logic       wpchg_q;
    logic       wpchg_d;
    logic       rdy_prev_q;
    logic       wp_prev_q;
    logic       we_prev_q;
    logic       we_prev_d;
    pwr_e       pwr_q;
    pwr_e       pwr_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       rd_oe_q;
    logic       rd_oe_d;

    logic       cfg_sel;
    logic       wr_stb;
    logic       rd_act;
    logic       soft_rst;
    logic       rdy_live;
    logic       wp_live;
    logic       changed;
    logic       irq_view;
    logic       io_cfg;
    decode_e    decode;

    // Only even, 8-bit attribute accesses with A9 high reach the bank
    assign cfg_sel = !attr_bus.ce1_n && !attr_bus.reg_n
                     && attr_bus.addr[9] && !attr_bus.addr[0];
    // Write takes effect once, on the falling edge of the write strobe
    assign wr_stb  = cfg_sel && !attr_bus.we_n && attr_bus.oe_n
                     && we_prev_q;
    assign rd_act  = cfg_sel && !attr_bus.oe_n && attr_bus.we_n;

    assign soft_rst = opt_q[`CCFG_OPT_SOFT_RESET_BIT];
    assign wp_live  = 1'b0;
    assign changed  = rdychg_q | wpchg_q;
    assign irq_view = core_irq & !irq_disable_bit;

    // Card is busy while a power transition is pending
    assign rdy_live = core_ready && (pwr_q == PWR_ACTIVE
                      || pwr_q == PWR_DOWN);

    // Indices beyond 3 are unsupported; they fall back to memory decode
    always_comb
    begin
        case (opt_q[`CCFG_OPT_IDX_HI:0])
            `CCFG_IDX_IO_ANY: decode = DEC_IO_ANY;
            `CCFG_IDX_IO_PRI: decode = DEC_IO_PRI;
            `CCFG_IDX_IO_SEC: decode = DEC_IO_SEC;
            default:          decode = DEC_MEMORY;
        endcase
    end
    assign io_cfg = (decode != DEC_MEMORY);

    // Register writes
    always_comb
    begin
        opt_d     = opt_q;
        change_signal_enable_d  = change_signal_enable_q;
        byteio_d  = byteio_q;
        psave_d   = psave_q;
        rdychg_d  = rdychg_q;
        wpchg_d   = wpchg_q;
        we_prev_d = attr_bus.we_n;
        if (wr_stb && attr_bus.addr == `CCFG_OFS_OPTION)
        begin
            opt_d = attr_bus.wdata;
        end
        if (wr_stb && attr_bus.addr == `CCFG_OFS_STATUS)
        begin
            change_signal_enable_d = attr_bus.wdata[`CCFG_ST_CHANGE_SIGNAL_ENABLE];
            byteio_d = attr_bus.wdata[`CCFG_ST_BYTEIO];
            psave_d  = attr_bus.wdata[`CCFG_ST_PWRDN];
        end
        if (wr_stb && attr_bus.addr == `CCFG_OFS_PINREP)
        begin
            if (attr_bus.wdata[`CCFG_PR_RDYLIVE])
                rdychg_d = attr_bus.wdata[`CCFG_PR_RDYCHG];
            if (attr_bus.wdata[`CCFG_PR_WPLIVE])
                wpchg_d = attr_bus.wdata[`CCFG_PR_WPCHG];
        end
        // Hardware edge wins over a host clear in the same cycle
        if (rdy_live != rdy_prev_q)
            rdychg_d = 1'b1;
        if (wp_live != wp_prev_q)
            wpchg_d = 1'b1;
    end

    // Power state: host request or automatic idle/command transitions
    always_comb
    begin
        pwr_d = pwr_q;
        case (pwr_q)
            PWR_ACTIVE:
                if (psave_d != psave_q && psave_d)
                    pwr_d = PWR_TO_DOWN;
                else if (core_idle && !core_command)
                    pwr_d = PWR_TO_DOWN;
            PWR_TO_DOWN:
                if (power_reached)
                    pwr_d = PWR_DOWN;
            PWR_DOWN:
                if (psave_d != psave_q && !psave_d)
                    pwr_d = PWR_TO_UP;
                else if (core_command && !psave_q)
                    pwr_d = PWR_TO_UP;
            PWR_TO_UP:
                if (power_reached)
                    pwr_d = PWR_ACTIVE;
            default:
                pwr_d = PWR_ACTIVE;
        endcase
        // A change of request toward the current state still flags busy
        if (psave_d != psave_q && pwr_d == pwr_q)
            pwr_d = psave_d ? PWR_TO_DOWN : PWR_TO_UP;
    end

    // Read mux; constant bits and read-only bits come from logic only
    always_comb
    begin
        rdata_d = 8'h00;
        rd_oe_d = rd_act;
        case (attr_bus.addr)
            `CCFG_OFS_OPTION:
                rdata_d = opt_q;
            `CCFG_OFS_STATUS:
            begin
                rdata_d[`CCFG_ST_CHANGED] = changed;
                rdata_d[`CCFG_ST_CHANGE_SIGNAL_ENABLE]  = change_signal_enable_q;
                rdata_d[`CCFG_ST_BYTEIO]  = byteio_q;
                rdata_d[`CCFG_ST_PWRDN]   = psave_q;
                rdata_d[`CCFG_ST_INT]     = irq_view;
            end
            `CCFG_OFS_PINREP:
            begin
                rdata_d[`CCFG_PR_RDYCHG]    = rdychg_q;
                rdata_d[`CCFG_PR_WPCHG]     = wpchg_q;
                rdata_d[`CCFG_PR_ONES]      = 1'b1;
                rdata_d[`CCFG_PR_ONES - 1]  = 1'b1;
                rdata_d[`CCFG_PR_RDYLIVE]   = rdy_live;
                rdata_d[`CCFG_PR_WPLIVE]    = wp_live;
            end
            default:
                rdata_d = 8'h00;
        endcase
        if (!rd_act)
            rdata_d = 8'h00;
    end

    // Option register is reset by hardware; soft reset clears all of it but the soft reset bit
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            opt_q <= `CCFG_OPT_RESET;
        else if (soft_rst)
            // Only the soft reset bit survives its own reset
            opt_q <= {opt_d[`CCFG_OPT_SOFT_RESET_BIT], 7'h00};
        else
            opt_q <= opt_d;
    end

    // Remaining state is reset by hardware; soft reset clears all but the edge trackers and read path
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            change_signal_enable_q   <= 1'b0;
            byteio_q   <= 1'b0;
            psave_q    <= 1'b0;
            rdychg_q   <= 1'b0;
            wpchg_q    <= 1'b0;
            // Matches the ready level after reset, so no false change flag
            rdy_prev_q <= 1'b1;
            wp_prev_q  <= 1'b0;
            we_prev_q  <= 1'b1;
            pwr_q      <= PWR_ACTIVE;
            rdata_q    <= 8'h00;
            rd_oe_q    <= 1'b0;
        end
        else if (soft_rst)
        begin
            change_signal_enable_q   <= 1'b0;
            byteio_q   <= 1'b0;
            psave_q    <= 1'b0;
            rdychg_q   <= 1'b0;
            wpchg_q    <= 1'b0;
            rdy_prev_q <= rdy_live;
            wp_prev_q  <= wp_live;
            we_prev_q  <= we_prev_d;
            pwr_q      <= PWR_ACTIVE;
            rdata_q    <= rdata_d;
            rd_oe_q    <= rd_oe_d;
        end
        else
        begin
            change_signal_enable_q   <= change_signal_enable_d;
            byteio_q   <= byteio_d;
            psave_q    <= psave_d;
            rdychg_q   <= rdychg_d;
            wpchg_q    <= wpchg_d;
            rdy_prev_q <= rdy_live;
            wp_prev_q  <= wp_live;
            we_prev_q  <= we_prev_d;
            pwr_q      <= pwr_d;
            rdata_q    <= rdata_d;
            rd_oe_q    <= rd_oe_d;
        end
    end

    assign rdata    = rdata_q;
    assign rdata_oe = rd_oe_q;

    // Soft reset drives the core's hard reset input, not its ATA soft reset
    assign card_ctl.card_reset         = soft_rst;
    assign card_ctl.level_irq_select   = opt_q[`CCFG_OPT_LEVEL];
    assign card_ctl.decode             = decode;
    assign card_ctl.io_configured      = io_cfg;
    assign card_ctl.power_save_request = psave_q;

    // Pin is meaningful only in I/O mode; memory mode keeps it idle high
    assign status_change_out = !(io_cfg && change_signal_enable_q && changed);
    assign ready_busy_out    = rdy_live;
    assign power_down_active = (pwr_q == PWR_DOWN);

endmodule

// [pkg/card_cfg_map.svh]
/*
 * Offsets, field positions and reset values of the card configuration
 * registers. Assumes inclusion by bare name from the design and bench.
 */
`ifndef CARD_CFG_MAP_SVH
`define CARD_CFG_MAP_SVH

`define CCFG_OFS_OPTION      11'h200
`define CCFG_OFS_STATUS      11'h202
`define CCFG_OFS_PINREP      11'h204

`define CCFG_OPT_SOFT_RESET_BIT      7
`define CCFG_OPT_LEVEL       6
`define CCFG_OPT_IDX_HI      5
`define CCFG_OPT_RESET       8'h00

`define CCFG_ST_CHANGED      7
`define CCFG_ST_CHANGE_SIGNAL_ENABLE       6
`define CCFG_ST_BYTEIO       5
`define CCFG_ST_PWRDN        2
`define CCFG_ST_INT          1
`define CCFG_ST_RESET        8'h00

`define CCFG_PR_RDYCHG       5
`define CCFG_PR_WPCHG        4
`define CCFG_PR_ONES         3
`define CCFG_PR_RDYLIVE      1
`define CCFG_PR_WPLIVE       0

`define CCFG_IDX_MEM         6'h00
`define CCFG_IDX_IO_ANY      6'h01
`define CCFG_IDX_IO_PRI      6'h02
`define CCFG_IDX_IO_SEC      6'h03

`endif

// [pkg/card_cfg_pkg.sv]
/*
 * Types for the card configuration register bank.
 * Assumes the map header sits on the include path.
 */
package card_cfg_pkg;

    typedef enum logic [1:0]
    {
        DEC_MEMORY = 2'b00,
        DEC_IO_ANY = 2'b01,
        DEC_IO_PRI = 2'b10,
        DEC_IO_SEC = 2'b11
    } decode_e;

    typedef enum logic [1:0]
    {
        PWR_ACTIVE   = 2'b00,
        PWR_TO_DOWN  = 2'b01,
        PWR_DOWN     = 2'b10,
        PWR_TO_UP    = 2'b11
    } pwr_e;

    // Attribute memory access strobes as seen at the card pins
    typedef struct packed
    {
        logic        ce1_n;
        logic        reg_n;
        logic        oe_n;
        logic        we_n;
        logic [10:0] addr;
        logic [7:0]  wdata;
    } attr_bus_s;

    // Settings that steer the rest of the card
    typedef struct packed
    {
        logic    card_reset;
        logic    level_irq_select;
        decode_e decode;
        logic    io_configured;
        logic    power_save_request;
    } card_ctl_s;

endpackage

// [tb/card_cfg_assertions.sv]
/*
 * Port checker for the card configuration bank.
 * Assumes binding to every instance of the bank, one clock domain.
 */
`timescale 1ns/1ps

module card_cfg_checker
    import card_cfg_pkg::*;
(
    // Clock and reset
    input wire logic       mclk,
    input wire logic       rst,
    // Bus side
    input wire attr_bus_s  attr_bus,
    input wire logic [7:0] rdata,
    input wire logic       rdata_oe,
    // Control side
    input wire logic       power_reached,
    input wire card_ctl_s  card_ctl,
    input wire logic       ready_busy_out,
    input wire logic       power_down_active
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    logic rd_sel;
    assign rd_sel = !attr_bus.ce1_n && !attr_bus.reg_n && !attr_bus.oe_n
                    && attr_bus.we_n && attr_bus.addr[9] && !attr_bus.addr[0];

    chk_reset_clear: assert property (
        $past(rst) |-> !card_ctl.card_reset && card_ctl.decode == DEC_MEMORY)
        else $error("Control not clear after reset");
    chk_soft_reset_bit_hold: assert property (
        card_ctl.card_reset |=> card_ctl.decode == DEC_MEMORY
        && !card_ctl.level_irq_select && !card_ctl.power_save_request)
        else $error("Soft reset did not hold card in reset");
    chk_io_decode: assert property (
        card_ctl.io_configured == (card_ctl.decode != DEC_MEMORY))
        else $error("I/O flag disagrees with decode");
    chk_busy_req: assert property (
        $changed(card_ctl.power_save_request) |-> ##[0:1] !ready_busy_out)
        else $error("No busy after power request change");
    chk_rdata_idle: assert property (
        !rdata_oe |-> rdata == 8'h00)
        else $error("Read data not zero while idle");
    chk_read_oe: assert property (
        rd_sel |=> rdata_oe)
        else $error("Register read not answered");
    chk_oe_idle: assert property (
        attr_bus.oe_n |=> !rdata_oe)
        else $error("Read enable without read strobe");
    chk_down_reach: assert property (
        $rose(power_down_active) |-> $past(power_reached))
        else $error("Power down entered without completion");
    chk_up_reach: assert property (
        $fell(power_down_active) && !card_ctl.card_reset |-> !ready_busy_out)
        else $error("Wake from power down not busy");

    cover property (card_ctl.card_reset);
    cover property ($rose(power_down_active));
    cover property (rdata_oe && rdata != 8'h00);
endmodule

bind card_config_register_bank card_cfg_checker chk (
    .mclk(mclk), .rst(rst), .attr_bus(attr_bus), .rdata(rdata),
    .rdata_oe(rdata_oe), .power_reached(power_reached),
    .card_ctl(card_ctl), .ready_busy_out(ready_busy_out),
    .power_down_active(power_down_active));

// [tb/card_host_model.sv]
/*
 * Host socket model driving attribute memory strobes.
 * Assumes the bench calls its tasks; strobes change on falling edges.
 */
`timescale 1ns/1ps

module card_host_model
    import card_cfg_pkg::*;
(
    // Clock and read data
    input  wire logic       mclk,
    input  wire logic [7:0] rdata,
    // Strobes towards the card
    output attr_bus_s       bus
);
    initial bus = '{1'b1, 1'b1, 1'b1, 1'b1, 11'h7ff, 8'hff};

    // Released lines show the inverse so stale values cannot match
    task automatic idle();
        bus = '{1'b1, 1'b1, 1'b1, 1'b1, ~bus.addr, ~bus.wdata};
    endtask

    // Byte accesses only; one high cycle between strobes
    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        @(negedge mclk);
        bus = '{1'b0, 1'b0, 1'b1, 1'b0, a, d};
        @(negedge mclk);
        idle();
    endtask

    task automatic rd(input logic [10:0] a, output logic [7:0] d);
        @(negedge mclk);
        bus = '{1'b0, 1'b0, 1'b0, 1'b1, a, ~bus.wdata};
        @(negedge mclk);
        d = rdata;
        idle();
    endtask
endmodule

// [tb/testbench.sv]
/*
 * Register bank bench: host accesses with expected values.
 * Assumes the host model and checker compile beforehand.
 */
`timescale 1ns/1ps
`include "card_cfg_map.svh"

module testbench
    import card_cfg_pkg::*;
;
    localparam logic [10:0] OPT = `CCFG_OFS_OPTION;
    localparam logic [10:0] ST  = `CCFG_OFS_STATUS;
    localparam logic [10:0] PR  = `CCFG_OFS_PINREP;
    logic       mclk = 1'b0, rst = 1'b1, irq = 1'b0, dis = 1'b0;
    logic       rdy = 1'b1, idl = 1'b0, cmd = 1'b0, reach_q = 1'b0;
    logic       oe, scg, rbo, pda;
    logic [7:0] rdata, v;
    attr_bus_s  bus;
    card_ctl_s  ctl;
    int         n_mismatch = 0, checked = 0;

    always #25 mclk = ~mclk;

    card_config_register_bank DUT (
        .mclk(mclk), .rst(rst), .attr_bus(bus), .rdata(rdata),
        .rdata_oe(oe), .core_irq(irq), .irq_disable_bit(dis),
        .core_ready(rdy), .core_idle(idl), .core_command(cmd),
        .power_reached(reach_q), .card_ctl(ctl),
        .status_change_out(scg), .ready_busy_out(rbo),
        .power_down_active(pda));
    card_host_model host (.mclk(mclk), .rdata(rdata), .bus(bus));

    task automatic chk(input string nm, input logic [7:0] s, e);
        checked++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic rc(input string nm, input logic [10:0] a,
                      input logic [7:0] e);
        host.rd(a, v);
        chk(nm, v, e);
        chk("read_enable", 8'(oe), 8'h01);
    endtask

    task automatic reach();
        @(negedge mclk) reach_q = 1'b1;
        @(negedge mclk) reach_q = 1'b0;
    endtask

    task automatic final_report();
        $display("Checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Hang guard
    initial
    begin
        repeat (5000) @(posedge mclk);
        n_mismatch++;
        final_report();
    end

    initial
    begin
        repeat (2) @(posedge mclk);
        @(negedge mclk) rst = 1'b0;
        rc("option", OPT, 8'h00);
        rc("status", ST, 8'h00);
        rc("pinrep", PR, 8'h0e);
        for (int i = 0; i < 6; i++)
        begin
            host.wr(OPT, 8'h40 | 8'(i));
            rc("option", OPT, 8'h40 | 8'(i));
            chk("decode", 8'(ctl.decode), i < 4 ? 8'(i) : 8'h00);
        end
        host.wr(OPT, 8'h01);
        host.wr(ST, 8'hfb);
        rc("status", ST, 8'h60);
        rdy = 1'b0;
        rc("pinrep", PR, 8'h2c);
        rc("status", ST, 8'he0);
        chk("status_change_out", 8'(scg), 8'h00);
        host.wr(PR, 8'h20);
        rc("pinrep", PR, 8'h2c);
        host.wr(PR, 8'h02);
        rc("pinrep", PR, 8'h0c);
        host.wr(PR, 8'h11);
        rc("pinrep", PR, 8'h1c);
        host.wr(ST, 8'h20);
        chk("status_change_out", 8'(scg), 8'h01);
        rc("status", ST, 8'ha0);
        host.wr(PR, 8'h01);
        rc("pinrep", PR, 8'h0c);
        rdy = 1'b1;
        host.wr(ST, 8'h04);
        rc("status", ST, 8'h84);
        chk("busy", 8'(rbo), 8'h00);
        reach();
        chk("down", 8'(pda), 8'h01);
        irq = 1'b1;
        rc("status", ST, 8'h86);
        dis = 1'b1;
        rc("status", ST, 8'h84);
        irq = 1'b0;
        dis = 1'b0;
        host.wr(ST, 8'h00);
        chk("busy", 8'(rbo), 8'h00);
        reach();
        chk("down", 8'(pda), 8'h00);
        idl = 1'b1;
        reach();
        idl = 1'b0;
        chk("down", 8'(pda), 8'h01);
        cmd = 1'b1;
        reach();
        cmd = 1'b0;
        chk("down", 8'(pda), 8'h00);
        host.wr(11'h201, 8'h85);
        host.wr(11'h206, 8'h85);
        rc("option", OPT, 8'h01);
        host.rd(11'h201, v);
        chk("odd", v, 8'h00);
        chk("odd_oe", 8'(oe), 8'h00);
        host.wr(OPT, 8'hc3);
        chk("card_reset", 8'(ctl.card_reset), 8'h01);
        rc("option", OPT, 8'h80);
        host.wr(OPT, 8'h00);
        rc("option", OPT, 8'h00);
        chk("decode", 8'(ctl.decode), 8'h00);
        final_report();
    end
endmodule
